// [common/sltx_cfg.svh]
`ifndef SLTX_CFG_SVH
`define SLTX_CFG_SVH
// Register indexes; the bus byte address is four times the index
`define SLTX_IDX_DENSITY     12'h592
`define SLTX_IDX_CKSUM0      12'h5A0
`define SLTX_IDX_CKSUM1      12'h5A1
`define SLTX_IDX_PWRDN       12'h5B0
`define SLTX_IDX_MAP0        12'h5B2
`define SLTX_IDX_MAP1        12'h5B3
`define SLTX_IDX_SWING0      12'h5C0
`define SLTX_IDX_SWING1      12'h5C1
`define SLTX_IDX_LINKP0      12'h600
`define SLTX_IDX_LINKP1      12'h601
// Field positions
`define SLTX_HD_BIT          7
`define SLTX_PD_LANE0_BIT    0
`define SLTX_PD_LANE1_BIT    2
// Reset values
`define SLTX_RST_PWRDN       8'hFA
`define SLTX_RST_MAP0        8'h00
`define SLTX_RST_MAP1        8'h11
`define SLTX_RST_SWING       8'h01
`define SLTX_RST_CKSUM0      8'hC3
`define SLTX_RST_CKSUM1      8'hC4
`define SLTX_RST_LINKP       8'h00
// Writable masks
`define SLTX_WMASK_PWRDN     8'hFF
`define SLTX_WMASK_MAP       8'h77
`define SLTX_WMASK_SWING     8'h07
`define SLTX_WMASK_LINKP     8'hFF
`endif

// [common/sltx_lane_if.sv]
`timescale 1ns/100ps
// Per-lane controls handed from the register file to the lane slice
interface sltx_lane_if;
  logic [7:0] linkp;      // Sum of lane link parameters, software-set
  logic [2:0] lsel;       // Logical lane chosen
  logic [3:0] lanes_in;   // Logical lane bits
  logic       pd;         // Force power-down
  logic [2:0] swing;      // Swing code
  logic       ser_out;    // Routed bit
  logic       ser_oe;     // Lane driving
  logic [2:0] swing_out;  // Swing applied
  modport regs (output linkp, lsel, lanes_in, pd, swing, input ser_out, ser_oe, swing_out);
  modport lane (input linkp, lsel, lanes_in, pd, swing, output ser_out, ser_oe, swing_out);
endinterface

// [common/sltx_pkg.sv]
package sltx_pkg;
  // Bus response codes
  typedef enum logic [1:0] {
    SLTX_RESP_OKAY   = 2'b00,
    SLTX_RESP_SLVERR = 2'b10
  } sltx_resp_t;
  // Logical lane selector
  typedef logic [2:0] sltx_lsel_t;
endpackage

// [core/sltx_cksum.sv]
`timescale 1ns/100ps
// Modulo-256 sum of per-lane link parameter bytes
module sltx_cksum
  import sltx_pkg::*;
(
  input  wire logic [7:0] base,
  input  wire logic [7:0] lane_param,
  output logic      [7:0] sum
);
  // Eight-bit add wraps naturally, giving the mod 256
  assign sum = base + lane_param;
endmodule

// [core/sltx_lane.sv]
`timescale 1ns/100ps
// One physical lane: routing, power-down, swing
module sltx_lane
  import sltx_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   nrst,
  sltx_lane_if.lane   lif
);
  typedef struct packed {
    logic       out;
    logic       oe;
    logic [2:0] sw;
  } sltx_lane_st_t;
  sltx_lane_st_t st_reg;   // State
  sltx_lane_st_t st_next;  // Next state

  // Route chosen logical lane; codes above 3 give idle zero
  always_comb begin
    st_next     = st_reg;
    st_next.out = (lif.lsel < 3'h4) ? lif.lanes_in[lif.lsel[1:0]] : 1'b0;
    st_next.oe  = ~lif.pd;
    st_next.sw  = lif.swing;
    if (lif.pd) begin
      st_next.out = 1'b0;
    end
  end

  // Register
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign lif.ser_out   = st_reg.out;
  assign lif.ser_oe    = st_reg.oe;
  assign lif.swing_out = st_reg.sw;

  property p_pd_off;
    @(posedge core_clk) disable iff (!nrst) lif.pd |=> !lif.ser_oe;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("lane driving while powered down");
endmodule

// [core/sltx_regs.sv]
`timescale 1ns/100ps
`include "sltx_cfg.svh"
module sltx_regs
  import sltx_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // AXI4-Lite write address
  input  wire logic [13:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // Write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // Write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read address
  input  wire logic [13:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // Read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Link status from the framer
  input  wire logic        high_density_flag,
  input  wire logic [4:0]  ctrl_words_per_frame,
  input  wire logic [3:0]  logical_lanes,
  // Physical lanes
  output logic             serial_out_lane0,
  output logic             serial_out_lane0_oe,
  output logic             serial_out_lane1,
  output logic             serial_out_lane1_oe,
  output logic [2:0]       lane0_swing,
  output logic [2:0]       lane1_swing
);
  ////////////////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic       aw_held;   // Address latched
    logic [11:0] aw_idx;   // Latched index
    logic       w_held;    // Data latched
    logic [7:0] w_data;    // Latched byte
    logic       w_en;      // Byte lane 0 enabled
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [7:0] pwrdn;     // Lane power-down
    logic [7:0] map0;
    logic [7:0] map1;
    logic [7:0] swing0;
    logic [7:0] swing1;
    logic [7:0] linkp0;    // Lane 0 parameter byte sum, loaded by software
    logic [7:0] linkp1;
  } sltx_regs_st_t;
  sltx_regs_st_t st_reg;   // Registered state
  sltx_regs_st_t st_next;  // Next state

  logic [7:0] cksum0;      // Lane 0 checksum
  logic [7:0] cksum1;      // Lane 1 checksum
  logic [7:0] rd_val;      // Read mux
  logic       rd_hit;      // Mapped read
  logic       wr_hit;      // Mapped write
  logic [11:0] ar_idx;     // Read index

  sltx_lane_if l0 ();
  sltx_lane_if l1 ();

  ////////////////////////////////////////////////////////////////////////////////////////
  // Checksums: reset value offsets plus software parameter sum, so reset reads match
  sltx_cksum u_ck0 (
    .base       (8'(`SLTX_RST_CKSUM0)),
    .lane_param (st_reg.linkp0),
    .sum        (cksum0)
  );
  sltx_cksum u_ck1 (
    .base       (8'(`SLTX_RST_CKSUM1)),
    .lane_param (st_reg.linkp1),
    .sum        (cksum1)
  );

  ////////////////////////////////////////////////////////////////////////////////////////
  // Lane slices
  assign l0.linkp    = st_reg.linkp0;
  assign l0.lsel     = st_reg.map0[2:0];
  assign l0.lanes_in = logical_lanes;
  assign l0.pd       = st_reg.pwrdn[`SLTX_PD_LANE0_BIT];
  assign l0.swing    = st_reg.swing0[2:0];
  assign l1.linkp    = st_reg.linkp1;
  assign l1.lsel     = st_reg.map1[2:0];
  assign l1.lanes_in = logical_lanes;
  assign l1.pd       = st_reg.pwrdn[`SLTX_PD_LANE1_BIT];
  assign l1.swing    = st_reg.swing1[2:0];

  sltx_lane u_lane0 (
    .core_clk (core_clk),
    .nrst     (nrst),
    .lif      (l0)
  );
  sltx_lane u_lane1 (
    .core_clk (core_clk),
    .nrst     (nrst),
    .lif      (l1)
  );

  assign serial_out_lane0    = l0.ser_out;
  assign serial_out_lane0_oe = l0.ser_oe;
  assign serial_out_lane1    = l1.ser_out;
  assign serial_out_lane1_oe = l1.ser_oe;
  assign lane0_swing         = l0.swing_out;
  assign lane1_swing         = l1.swing_out;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Read decode; byte address is four times the printed index
  assign ar_idx = s_axi_araddr[13:2];
  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    unique case (ar_idx)
      `SLTX_IDX_DENSITY: begin
        rd_val = {high_density_flag, 2'b00, ctrl_words_per_frame};
      end
      `SLTX_IDX_CKSUM0: begin
        rd_val = cksum0;
      end
      `SLTX_IDX_CKSUM1: begin
        rd_val = cksum1;
      end
      `SLTX_IDX_PWRDN:  rd_val = st_reg.pwrdn;
      `SLTX_IDX_MAP0:   rd_val = st_reg.map0;
      `SLTX_IDX_MAP1:   rd_val = st_reg.map1;
      `SLTX_IDX_SWING0: rd_val = st_reg.swing0;
      `SLTX_IDX_SWING1: rd_val = st_reg.swing1;
      `SLTX_IDX_LINKP0: rd_val = st_reg.linkp0;
      `SLTX_IDX_LINKP1: rd_val = st_reg.linkp1;
      default: begin
        rd_hit = 1'b0;   // Unmapped address answers SLVERR
      end
    endcase
  end

  // Write hit check on the latched index
  always_comb begin
    unique case (st_reg.aw_idx)
      `SLTX_IDX_DENSITY, `SLTX_IDX_CKSUM0, `SLTX_IDX_CKSUM1,
      `SLTX_IDX_PWRDN, `SLTX_IDX_MAP0, `SLTX_IDX_MAP1,
      `SLTX_IDX_SWING0, `SLTX_IDX_SWING1,
      `SLTX_IDX_LINKP0, `SLTX_IDX_LINKP1: wr_hit = 1'b1;
      default:                           wr_hit = 1'b0;
    endcase
  end

  // Ready while nothing is latched and no response is pending
  assign s_axi_awready = !st_reg.aw_held && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_held && !st_reg.bvalid;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rresp   = st_reg.rresp;
  assign s_axi_rdata   = {24'h000000, st_reg.rdata};

  ////////////////////////////////////////////////////////////////////////////////////////
  // Next state: channel capture, register writes, responses
  always_comb begin
    st_next = st_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_held = 1'b1;
      st_next.aw_idx  = s_axi_awaddr[13:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata[7:0];
      st_next.w_en   = s_axi_wstrb[0];
    end
    // Both halves present: commit and respond
    if (st_reg.aw_held && st_reg.w_held) begin
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = wr_hit ? SLTX_RESP_OKAY : SLTX_RESP_SLVERR;
      if (st_reg.w_en) begin
        // Read-only registers and bits keep device values
        unique case (st_reg.aw_idx)
          `SLTX_IDX_PWRDN:  st_next.pwrdn  = st_reg.w_data & 8'(`SLTX_WMASK_PWRDN);
          `SLTX_IDX_MAP0:   st_next.map0   = st_reg.w_data & 8'(`SLTX_WMASK_MAP);
          `SLTX_IDX_MAP1:   st_next.map1   = st_reg.w_data & 8'(`SLTX_WMASK_MAP);
          `SLTX_IDX_SWING0: st_next.swing0 = st_reg.w_data & 8'(`SLTX_WMASK_SWING);
          `SLTX_IDX_SWING1: st_next.swing1 = st_reg.w_data & 8'(`SLTX_WMASK_SWING);
          `SLTX_IDX_LINKP0: st_next.linkp0 = st_reg.w_data;
          `SLTX_IDX_LINKP1: st_next.linkp1 = st_reg.w_data;
          default: begin
            st_next.pwrdn = st_reg.pwrdn;
          end
        endcase
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // Read
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = rd_val;
      st_next.rresp  = rd_hit ? SLTX_RESP_OKAY : SLTX_RESP_SLVERR;
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Register stage
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_reg        <= '0;
      st_reg.pwrdn  <= `SLTX_RST_PWRDN;
      st_reg.map0   <= `SLTX_RST_MAP0;
      st_reg.map1   <= `SLTX_RST_MAP1;
      st_reg.swing0 <= `SLTX_RST_SWING;
      st_reg.swing1 <= `SLTX_RST_SWING;
      st_reg.linkp0 <= `SLTX_RST_LINKP;
      st_reg.linkp1 <= `SLTX_RST_LINKP;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_ro_cksum;
    @(posedge core_clk) disable iff (!nrst)
      (s_axi_arvalid && s_axi_arready && ar_idx == `SLTX_IDX_CKSUM0)
      |=> (s_axi_rdata[7:0] == 8'(st_reg.linkp0 + 8'hC3));
  endproperty
  a_ro_cksum: assert property (p_ro_cksum) else $error("lane0 checksum read wrong");

  property p_ck1;
    @(posedge core_clk) disable iff (!nrst)
      (s_axi_arvalid && s_axi_arready && ar_idx == `SLTX_IDX_CKSUM1)
      |=> (s_axi_rdata[7:0] == 8'(st_reg.linkp1 + 8'hC4));
  endproperty
  a_ck1: assert property (p_ck1) else $error("lane1 checksum read wrong");

  property p_density;
    @(posedge core_clk) disable iff (!nrst)
      (s_axi_arvalid && s_axi_arready && ar_idx == `SLTX_IDX_DENSITY)
      ##1 s_axi_rvalid |-> s_axi_rdata[7] == $past(high_density_flag)
      && s_axi_rdata[4:0] == $past(ctrl_words_per_frame) && s_axi_rdata[6:5] == 2'b00;
  endproperty
  a_density: assert property (p_density) else $error("density register read wrong");

  property p_cf;
    @(posedge core_clk) disable iff (!nrst)
      (s_axi_arvalid && s_axi_arready && ar_idx == `SLTX_IDX_DENSITY)
      |=> s_axi_rdata[4:0] == $past(ctrl_words_per_frame);
  endproperty
  a_cf: assert property (p_cf) else $error("control word count wrong");

  property p_pd1;
    @(posedge core_clk) disable iff (!nrst)
      st_reg.pwrdn[2] ##1 st_reg.pwrdn[2] |-> !serial_out_lane1_oe;
  endproperty
  a_pd1: assert property (p_pd1) else $error("lane1 not powered down");

  property p_pd0;
    @(posedge core_clk) disable iff (!nrst)
      (nrst && !st_reg.pwrdn[0]) ##1 !st_reg.pwrdn[0] |-> serial_out_lane0_oe;
  endproperty
  a_pd0: assert property (p_pd0) else $error("lane0 not operating");

  property p_map0;
    @(posedge core_clk) disable iff (!nrst)
      (!st_reg.pwrdn[0] && st_reg.map0[2:0] < 3'h4)
      |=> serial_out_lane0 == $past(logical_lanes[st_reg.map0[1:0]]);
  endproperty
  a_map0: assert property (p_map0) else $error("lane0 routing wrong");

  property p_map1;
    @(posedge core_clk) disable iff (!nrst)
      (!st_reg.pwrdn[2] && st_reg.map1[2:0] < 3'h4)
      |=> serial_out_lane1 == $past(logical_lanes[st_reg.map1[1:0]]);
  endproperty
  a_map1: assert property (p_map1) else $error("lane1 routing wrong");

  property p_swing;
    @(posedge core_clk) disable iff (!nrst)
      nrst |=> lane0_swing == $past(st_reg.swing0[2:0]) && lane1_swing == $past(st_reg.swing1[2:0]);
  endproperty
  a_swing: assert property (p_swing) else $error("swing not applied");

  property p_ro_write;
    @(posedge core_clk) disable iff (!nrst)
      (st_reg.aw_held && st_reg.w_held) |=> st_reg.map0[7] == 1'b0 && st_reg.map0[3] == 1'b0;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only bit written");

  property p_cksum_mod;
    @(posedge core_clk) disable iff (!nrst) cksum0 == 8'(st_reg.linkp0 + 8'hC3);
  endproperty
  a_cksum_mod: assert property (p_cksum_mod) else $error("checksum not mod 256");
endmodule

// [tb/sltx_rx_model.sv]
`timescale 1ns/100ps
// Receiving end of both physical lanes
module sltx_rx_model (
  input  wire logic core_clk,
  input  wire logic lane0,
  input  wire logic lane0_oe,
  input  wire logic lane1,
  input  wire logic lane1_oe,
  output logic      rx0,
  output logic      rx1,
  output logic      live0,
  output logic      live1
);
  // Known start so an idle lane toggles instead of staying unknown
  initial begin
    rx0 = 1'b0;
    rx1 = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // Dead lane shows a toggling pattern, never a stale bit
  always @(posedge core_clk) begin
    live0 <= lane0_oe;
    live1 <= lane1_oe;
    rx0   <= lane0_oe ? lane0 : ~rx0;
    rx1   <= lane1_oe ? lane1 : ~rx1;
  end
endmodule

// [tb/tb_serial_link_tx_config_regs.sv]
`timescale 1ns/100ps
`include "sltx_cfg.svh"
// Bench for the link transmitter register bank
module tb_serial_link_tx_config_regs
  import sltx_pkg::*;
  ;
  logic        core_clk, nrst;                      // Clock, sync reset
  logic [13:0] awaddr, araddr;                      // Byte addresses
  logic [31:0] wdata, rdata;                        // Bus data
  logic [3:0]  wstrb, lanes;                        // Strobes, logical lanes
  logic [1:0]  bresp, rresp;                        // Response codes
  logic        awvalid, awready, wvalid, wready;    // Write handshakes
  logic        bvalid, bready, arvalid, arready;    // Response, read address
  logic        rvalid, rready, hd;                  // Read data, density flag
  logic [4:0]  cf;                                  // Control words
  logic        so0, so1, oe0, oe1;                  // Lane bits, enables
  logic [2:0]  sw0, sw1;                            // Swing codes
  logic        rx0, rx1, lv0, lv1;                  // Receiver view
  int          fail_count, samples_checked;         // Tallies
  ////////////////////////////////////////////////////////////////
  sltx_regs uut (.core_clk(core_clk), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .high_density_flag(hd), .ctrl_words_per_frame(cf), .logical_lanes(lanes),
    .serial_out_lane0(so0), .serial_out_lane0_oe(oe0), .serial_out_lane1(so1),
    .serial_out_lane1_oe(oe1), .lane0_swing(sw0), .lane1_swing(sw1));
  sltx_rx_model rx (.core_clk(core_clk), .lane0(so0), .lane0_oe(oe0), .lane1(so1),
    .lane1_oe(oe1), .rx0(rx0), .rx1(rx1), .live0(lv0), .live1(lv1));
  ////////////////////////////////////////////////////////////////
  // Free-running 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Compare and tally
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Write one byte; each channel drops at the edge that takes it, watchdog ends a hang
  task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      r = bresp;
    end while (!bvalid);
    bready <= 1'b0;
    chk(r, er);
    // Let an edge pass so the next call never re-raises bready in this step
    @(posedge core_clk);
  endtask
  // Read one byte and compare data and response
  task automatic rd(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic [1:0]  r;
    logic [31:0] v;
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      r = rresp;
      v = rdata;
    end while (!rvalid);
    rready <= 1'b0;
    chk({r, v}, {er, 24'h000000, d});
    @(posedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////
  // Hang guard, far beyond the expected run
  initial begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    results();
  end
  // Main sequence
  initial begin
    logic [7:0] pd [4];
    logic       e;
    pd = '{8'hFB, 8'hFE, 8'hFF, 8'hFA};
    {nrst, awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
    {arvalid, rready, hd, cf, lanes} = '0;
    wstrb = 4'hF;
    fail_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    // Reset contents and lane state
    rd(`SLTX_IDX_CKSUM0, 8'hC3, SLTX_RESP_OKAY);
    rd(`SLTX_IDX_CKSUM1, 8'hC4, SLTX_RESP_OKAY);
    rd(`SLTX_IDX_PWRDN, 8'hFA, SLTX_RESP_OKAY);
    rd(`SLTX_IDX_MAP0, 8'h00, SLTX_RESP_OKAY);
    rd(`SLTX_IDX_MAP1, 8'h11, SLTX_RESP_OKAY);
    rd(`SLTX_IDX_SWING0, 8'h01, SLTX_RESP_OKAY);
    rd(`SLTX_IDX_SWING1, 8'h01, SLTX_RESP_OKAY);
    chk({oe0, oe1, sw0, sw1}, {2'b11, 3'h1, 3'h1});
    rd(12'h400, 8'h00, SLTX_RESP_SLVERR);
    wr(12'h400, 8'h5A, SLTX_RESP_SLVERR);
    $display("Test reset values done");
    // Status byte follows flag and count pins, writes bounce off
    for (int i = 0; i < 3; i++) begin
      hd <= i[0];
      cf <= (i == 2) ? 5'h00 : (i == 0) ? 5'h1F : 5'h15;
      @(posedge core_clk);
      rd(`SLTX_IDX_DENSITY, {i[0], 2'b00, cf}, SLTX_RESP_OKAY);
    end
    hd <= 1'b1;
    wr(`SLTX_IDX_DENSITY, 8'h7F, SLTX_RESP_OKAY);
    rd(`SLTX_IDX_DENSITY, 8'h80, SLTX_RESP_OKAY);
    $display("Test status byte done");
    // Checksums track parameter sums, wrap at 256, ignore writes
    wr(`SLTX_IDX_LINKP0, 8'h50, SLTX_RESP_OKAY);
    rd(`SLTX_IDX_CKSUM0, 8'h13, SLTX_RESP_OKAY);
    wr(`SLTX_IDX_LINKP1, 8'h3C, SLTX_RESP_OKAY);
    rd(`SLTX_IDX_CKSUM1, 8'h00, SLTX_RESP_OKAY);
    wr(`SLTX_IDX_CKSUM0, 8'hAA, SLTX_RESP_OKAY);
    rd(`SLTX_IDX_CKSUM0, 8'h13, SLTX_RESP_OKAY);
    $display("Test checksums done");
    // Force power-down of each lane
    for (int i = 0; i < 4; i++) begin
      wr(`SLTX_IDX_PWRDN, pd[i], SLTX_RESP_OKAY);
      repeat (3) @(posedge core_clk);
      chk({oe0, oe1, lv0, lv1}, {~pd[i][0], ~pd[i][2], ~pd[i][0], ~pd[i][2]});
      rd(`SLTX_IDX_PWRDN, pd[i], SLTX_RESP_OKAY);
    end
    $display("Test power-down done");
    // Lane codes 0 to 4 on both physical lanes, both bit polarities
    for (int p = 0; p < 2; p++) begin
      lanes <= p[0] ? 4'h9 : 4'h6;
      for (int c = 0; c < 5; c++) begin
        wr(`SLTX_IDX_MAP0, 8'(c), SLTX_RESP_OKAY);
        wr(`SLTX_IDX_MAP1, 8'(c), SLTX_RESP_OKAY);
        repeat (3) @(posedge core_clk);
        e = (c < 4) ? lanes[c] : 1'b0;
        chk({so0, so1, rx0, rx1}, {4{e}});
      end
    end
    wr(`SLTX_IDX_MAP0, 8'hFF, SLTX_RESP_OKAY);
    rd(`SLTX_IDX_MAP0, 8'h77, SLTX_RESP_OKAY);
    $display("Test lane mapping done");
    // All swing codes, reserved bits read back clear
    for (int c = 0; c < 8; c++) begin
      wr(`SLTX_IDX_SWING0, 8'(c) | 8'hF8, SLTX_RESP_OKAY);
      wr(`SLTX_IDX_SWING1, 8'(7 - c), SLTX_RESP_OKAY);
      repeat (3) @(posedge core_clk);
      chk({sw0, sw1}, {3'(c), 3'(7 - c)});
      rd(`SLTX_IDX_SWING0, 8'(c), SLTX_RESP_OKAY);
    end
    // Byte lane 0 strobe off: the write is answered but lands nowhere
    wstrb <= 4'hE;
    wr(`SLTX_IDX_SWING0, 8'h02, SLTX_RESP_OKAY);
    rd(`SLTX_IDX_SWING0, 8'h07, SLTX_RESP_OKAY);
    wstrb <= 4'hF;
    $display("Test swing select done");
    results();
  end
endmodule
